//--- inc/seq_pkg.sv
// Shared constants and types of the supply enable and reset sequencer.
// Assumes one 50 MHz clock and a 12-bit APB byte address.
package seq_pkg;

  typedef enum logic [3:0] {
    ST_SHUTDOWN   = 4'h1,
    ST_STANDBY    = 4'h2,
    ST_RAILS_WAIT = 4'h4,
    ST_OPERATING  = 4'h8
  } seq_state_t;

  // Positions of the comparator outputs in the synchroniser vector
  localparam int SYNC_W        = 8;
  localparam int SY_VIN        = 0;
  localparam int SY_EN_RISE    = 1;
  localparam int SY_EN_FALL    = 2;
  localparam int SY_EN_OPER    = 3;
  localparam int SY_FIVE_RISE  = 4;
  localparam int SY_FIVE_FALL  = 5;
  localparam int SY_THREE_RISE = 6;
  localparam int SY_CORE_RISE  = 7;

  // Strap code upper bounds per index
  localparam int IDX_N = 8;
  localparam logic [7:0] IDX_BOUND [0:IDX_N-1] = '{
    8'h0A, 8'h18, 8'h2A, 8'h3F, 8'h59, 8'h77, 8'h9C, 8'hC9
  };
  localparam logic [3:0] IDX_FW_UPDATE = 4'h8;
  // Per index: second address pair, low logic level
  localparam logic [8:0] ALT_PAIR_MAP  = 9'h05A;
  localparam logic [8:0] LOW_LEVEL_MAP = 9'h0CC;

  localparam logic [6:0] ADDR_A_PAIR0 = 7'h22;
  localparam logic [6:0] ADDR_B_PAIR0 = 7'h26;
  localparam logic [6:0] ADDR_A_PAIR1 = 7'h23;
  localparam logic [6:0] ADDR_B_PAIR1 = 7'h27;

  localparam logic [1:0] BOOT_EEPROM    = 2'h0;
  localparam logic [1:0] BOOT_HOST      = 2'h1;
  localparam logic [1:0] BOOT_FW_UPDATE = 2'h2;

  // Register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CONFIG = 12'h008;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

//--- core/supply_enable_reset_sequencer.sv
// Supply sequencer: shutdown, standby and operating control, reset
// release, hard reset and power-on strap latch, with an APB slave.
// Assumes asynchronous analog comparator outputs and a strap code from
// an ADC on pclk with a one-cycle valid strobe.
//
// Contract
// - Start only when both undervoltage comparators clear
// - Below standby: regulators and processor off
// - Standby: regulators on, processor off
// - Processor runs when operating and rails up; held in reset while the CTRL hold bit is set
// - Operating level, rail low: regulators on, processor off
// - Hysteresis between shutdown and standby
// - Reset held until five-volt rail rises
// - Hard reset when five-volt rail falls
// - Latch strap code once after power on
// - Strap code to index by upper bounds
// - Index selects address pair, level, boot
`timescale 1ns/100ps

module supply_enable_reset_sequencer
  import seq_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              vin_uvlo_clear,
  input  wire logic              en_above_standby,
  input  wire logic              en_above_standby_fall,
  input  wire logic              en_above_operating,
  input  wire logic              five_above_rising,
  input  wire logic              five_above_falling,
  input  wire logic              three_above_rising,
  input  wire logic              core_above_rising,
  input  wire logic [7:0]        strap_code,
  input  wire logic              strap_code_valid,
  output logic                   rail_enable,
  output logic                   device_reset_n,
  output logic                   processor_reset_n,
  output logic                   hard_reset,
  output logic      [3:0]        config_index,
  output logic      [6:0]        target_addr_a,
  output logic      [6:0]        target_addr_b,
  output logic                   logic_level_low,
  output logic      [1:0]        boot_mode,
  output logic                   config_valid
);

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] raw_in;

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic       rail_enable_r;
  logic       rail_enable_nxt;
  logic       five_ok_r;
  logic       five_ok_nxt;
  logic       hard_reset_r;
  logic       hard_reset_nxt;
  logic       device_reset_n_r;
  logic       device_reset_n_nxt;
  logic       processor_reset_n_r;
  logic       processor_reset_n_nxt;
  logic       all_rise;

  logic [IDX_N-1:0] over_bound;
  logic [3:0]       idx_calc;
  logic [3:0]       config_index_r;
  logic [3:0]       config_index_nxt;
  logic [6:0]       addr_a_r;
  logic [6:0]       addr_a_nxt;
  logic [6:0]       addr_b_r;
  logic [6:0]       addr_b_nxt;
  logic             level_low_r;
  logic             level_low_nxt;
  logic [1:0]       boot_r;
  logic [1:0]       boot_nxt;
  logic             cfg_valid_r;
  logic             cfg_valid_nxt;

  logic        hold_r;
  logic        hold_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        apb_done;

  // Comparator synchroniser
  assign raw_in = {core_above_rising, three_above_rising,
                   five_above_falling, five_above_rising,
                   en_above_operating, en_above_standby_fall,
                   en_above_standby, vin_uvlo_clear};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  assign all_rise = sync2_r[SY_FIVE_RISE] && sync2_r[SY_THREE_RISE] &&
                    sync2_r[SY_CORE_RISE];

  // Power state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SHUTDOWN: begin
        if (sync2_r[SY_VIN] && sync2_r[SY_EN_RISE]) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (sync2_r[SY_EN_OPER]) begin
          state_nxt = all_rise ? ST_OPERATING : ST_RAILS_WAIT;
        end
      end
      ST_RAILS_WAIT: begin
        if (!sync2_r[SY_EN_OPER]) begin
          state_nxt = ST_STANDBY;
        end else if (all_rise) begin
          state_nxt = ST_OPERATING;
        end
      end
      ST_OPERATING: begin
        if (!sync2_r[SY_EN_OPER]) begin
          state_nxt = ST_STANDBY;
        end else if (!all_rise) begin
          state_nxt = ST_RAILS_WAIT;
        end
      end
      default: begin
        state_nxt = ST_SHUTDOWN;
      end
    endcase
    // Falling threshold is lower than the entry threshold
    if (state_r != ST_SHUTDOWN &&
        (!sync2_r[SY_VIN] || !sync2_r[SY_EN_FALL])) begin
      state_nxt = ST_SHUTDOWN;
    end
    rail_enable_nxt = (state_nxt != ST_SHUTDOWN);
    // Five-volt good with its own rising and falling levels
    five_ok_nxt = five_ok_r;
    if (!rail_enable_nxt || !sync2_r[SY_FIVE_FALL]) begin
      five_ok_nxt = 1'b0;
    end else if (sync2_r[SY_FIVE_RISE]) begin
      five_ok_nxt = 1'b1;
    end
    hard_reset_nxt = !sync2_r[SY_FIVE_FALL];
    device_reset_n_nxt = five_ok_nxt && !hard_reset_nxt;
    processor_reset_n_nxt = (state_nxt == ST_OPERATING) &&
                            device_reset_n_nxt && !hold_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r             <= ST_SHUTDOWN;
      rail_enable_r       <= 1'b0;
      five_ok_r           <= 1'b0;
      hard_reset_r        <= 1'b1;
      device_reset_n_r    <= 1'b0;
      processor_reset_n_r <= 1'b0;
    end else begin
      state_r             <= state_nxt;
      rail_enable_r       <= rail_enable_nxt;
      five_ok_r           <= five_ok_nxt;
      hard_reset_r        <= hard_reset_nxt;
      device_reset_n_r    <= device_reset_n_nxt;
      processor_reset_n_r <= processor_reset_n_nxt;
    end
  end

  // Strap code decode: one compare per upper bound
  genvar gi;
  generate
    for (gi = 0; gi < IDX_N; gi++) begin : g_bound
      assign over_bound[gi] = (strap_code > IDX_BOUND[gi]);
    end
  endgenerate

  always_comb begin
    idx_calc = 4'h0;
    for (int i = 0; i < IDX_N; i++) begin
      idx_calc = idx_calc + {3'h0, over_bound[i]};
    end
  end

  // Strap latch: taken once per power on, set wins over clear
  always_comb begin
    config_index_nxt = config_index_r;
    addr_a_nxt       = addr_a_r;
    addr_b_nxt       = addr_b_r;
    level_low_nxt    = level_low_r;
    boot_nxt         = boot_r;
    cfg_valid_nxt    = cfg_valid_r;
    if (!cfg_valid_r && strap_code_valid && device_reset_n_r) begin
      cfg_valid_nxt    = 1'b1;
      config_index_nxt = idx_calc;
      if (ALT_PAIR_MAP[idx_calc]) begin
        addr_a_nxt = ADDR_A_PAIR1;
        addr_b_nxt = ADDR_B_PAIR1;
      end else begin
        addr_a_nxt = ADDR_A_PAIR0;
        addr_b_nxt = ADDR_B_PAIR0;
      end
      level_low_nxt = LOW_LEVEL_MAP[idx_calc];
      if (idx_calc == IDX_FW_UPDATE) begin
        boot_nxt = BOOT_FW_UPDATE;
      end else if (idx_calc[0]) begin
        boot_nxt = BOOT_HOST;
      end else begin
        boot_nxt = BOOT_EEPROM;
      end
    end else if (hard_reset_r) begin
      cfg_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_index_r <= 4'h0;
      addr_a_r       <= ADDR_A_PAIR0;
      addr_b_r       <= ADDR_B_PAIR0;
      level_low_r    <= 1'b0;
      boot_r         <= BOOT_EEPROM;
      cfg_valid_r    <= 1'b0;
    end else begin
      config_index_r <= config_index_nxt;
      addr_a_r       <= addr_a_nxt;
      addr_b_r       <= addr_b_nxt;
      level_low_r    <= level_low_nxt;
      boot_r         <= boot_nxt;
      cfg_valid_r    <= cfg_valid_nxt;
    end
  end

  // APB slave: one wait state, unmapped address answers with an error
  assign apb_done = psel && penable && pready_r;

  always_comb begin
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt  = DATA_ZERO;
    hold_nxt    = hold_r;
    if (psel && penable && !pready_r) begin
      case (paddr)
        REG_CTRL: begin
          prdata_nxt = {31'h0000_0000, hold_r};
        end
        REG_STATUS: begin
          prdata_nxt = {18'h0_0000, cfg_valid_r, five_ok_r,
                        sync2_r, state_r};
        end
        REG_CONFIG: begin
          prdata_nxt = {cfg_valid_r, 10'h000, boot_r, level_low_r,
                        addr_b_r, addr_a_r, config_index_r};
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (apb_done && pwrite && paddr == REG_CTRL) begin
      hold_nxt = pwdata[CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= DATA_ZERO;
      hold_r    <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      hold_r    <= hold_nxt;
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign rail_enable       = rail_enable_r;
  assign device_reset_n    = device_reset_n_r;
  assign processor_reset_n = processor_reset_n_r;
  assign hard_reset        = hard_reset_r;
  assign config_index      = config_index_r;
  assign target_addr_a     = addr_a_r;
  assign target_addr_b     = addr_b_r;
  assign logic_level_low   = level_low_r;
  assign boot_mode         = boot_r;
  assign config_valid      = cfg_valid_r;

  startup_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(rail_enable_r) |-> $past(sync2_r[SY_VIN] && sync2_r[SY_EN_RISE]))
    else $error("rails enabled without both undervoltage clears");

  shutdown_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_SHUTDOWN) |-> !rail_enable_r && !processor_reset_n_r)
    else $error("rail or processor on in shutdown");

  standby_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_STANDBY) |-> rail_enable_r && !processor_reset_n_r)
    else $error("standby output mismatch");

  proc_run_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    processor_reset_n_r |-> $past(sync2_r[SY_EN_OPER] && all_rise))
    else $error("processor released without operating conditions");

  rails_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_RAILS_WAIT) |-> rail_enable_r && !processor_reset_n_r)
    else $error("rail wait output mismatch");

  enable_hyst_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r != ST_SHUTDOWN && sync2_r[SY_VIN] && sync2_r[SY_EN_FALL])
    |=> (state_r != ST_SHUTDOWN))
    else $error("shutdown entered above falling enable level");

  reset_release_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(device_reset_n_r) |-> $past(sync2_r[SY_FIVE_RISE]))
    else $error("reset released before five-volt rising level");

  hard_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sync2_r[SY_FIVE_FALL] |=> hard_reset_r && !device_reset_n_r)
    else $error("no hard reset on five-volt collapse");

  strap_latch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(cfg_valid_r) |-> config_index_r == $past(idx_calc) &&
    $past(strap_code_valid && device_reset_n_r))
    else $error("strap latch mismatch");

  open_index_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!cfg_valid_r && strap_code_valid && device_reset_n_r &&
     strap_code <= IDX_BOUND[0]) |=> config_index_r == 4'h0)
    else $error("open strap did not give index zero");

  addr_pair_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_valid_r |->
    target_addr_b == target_addr_a + (ADDR_B_PAIR0 - ADDR_A_PAIR0))
    else $error("target address pair mismatch");

  sync_delay_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(sync2_r[SY_VIN]) |-> $past(sync1_r[SY_VIN]))
    else $error("synchroniser stage skipped");

endmodule

//--- verif/supply_enable_reset_sequencer_tb.sv
// Self-checking bench for the supply enable and reset sequencer.
// Assumes the comparator outputs are seen at the outputs 4 edges after a change.
`timescale 1ns/100ps

module supply_enable_reset_sequencer_tb
  import seq_pkg::*;
;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [7:0]       cmp;
  logic [7:0]       strap_code;
  logic             strap_code_valid;
  logic             rail_enable;
  logic             device_reset_n;
  logic             processor_reset_n;
  logic             hard_reset;
  logic [3:0]       config_index;
  logic [6:0]       target_addr_a;
  logic [6:0]       target_addr_b;
  logic             logic_level_low;
  logic [1:0]       boot_mode;
  logic             config_valid;
  logic [31:0]      q;
  logic             err;
  int               fail_count;
  int               comparisons;
  int               idx;
  logic [7:0]       codes [0:13] = '{8'h00, 8'h0A, 8'h0B, 8'h18, 8'h19,
    8'h2A, 8'h3F, 8'h40, 8'h59, 8'h77, 8'h9C, 8'hC9, 8'hCA, 8'hFF};
  // Indices using the second address pair, and the 1.8 V level
  logic [8:0]       alt_idx = 9'b0_0101_1010;
  logic [8:0]       low_idx = 9'b0_1100_1100;

  supply_enable_reset_sequencer uut (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .vin_uvlo_clear        (cmp[SY_VIN]),
    .en_above_standby      (cmp[SY_EN_RISE]),
    .en_above_standby_fall (cmp[SY_EN_FALL]),
    .en_above_operating    (cmp[SY_EN_OPER]),
    .five_above_rising     (cmp[SY_FIVE_RISE]),
    .five_above_falling    (cmp[SY_FIVE_FALL]),
    .three_above_rising    (cmp[SY_THREE_RISE]),
    .core_above_rising     (cmp[SY_CORE_RISE]),
    .strap_code            (strap_code),
    .strap_code_valid      (strap_code_valid),
    .rail_enable           (rail_enable),
    .device_reset_n        (device_reset_n),
    .processor_reset_n     (processor_reset_n),
    .hard_reset            (hard_reset),
    .config_index          (config_index),
    .target_addr_a         (target_addr_a),
    .target_addr_b         (target_addr_b),
    .logic_level_low       (logic_level_low),
    .boot_mode             (boot_mode),
    .config_valid          (config_valid)
  );

  always #10 pclk = ~pclk;

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Ends when pready rises, or by the watchdog if it never does; the slave inserts one wait state
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    chk("pready_wait", 32'(n), 32'h0000_0002);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // Changes the comparators and waits until the outputs have followed
  task automatic settle(input logic [7:0] v);
    cmp <= v;
    repeat (4) @(posedge pclk);
  endtask

  task automatic strap(input logic [7:0] code);
    strap_code       <= code;
    strap_code_valid <= 1'b1;
    @(posedge pclk);
    strap_code_valid <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    complete_run();
  end

  initial begin
    pclk             = 1'b0;
    presetn          = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 12'h000;
    pwdata           = 32'h0000_0000;
    cmp              = 8'h00;
    strap_code       = 8'h00;
    strap_code_valid = 1'b0;
    fail_count       = 0;
    comparisons      = 0;
    do_reset();
    chk("hard_reset", 32'(hard_reset), 32'h0000_0001);
    chk("addr_a", 32'(target_addr_a), 32'h0000_0022);
    apb(1'b0, REG_CTRL, DATA_ZERO);
    chk("ctrl", q, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    apb(1'b0, REG_CTRL, DATA_ZERO);
    chk("ctrl", q, 32'h0000_0001);
    apb(1'b1, REG_CTRL, DATA_ZERO);
    apb(1'b0, 12'hFFC, DATA_ZERO);
    chk("slverr", 32'(err), 32'h0000_0001);
    apb(1'b0, REG_CONFIG, DATA_ZERO);
    chk("config", q, 32'h0001_3220);
    strap(8'h50);
    chk("cfg_valid", 32'(config_valid), 32'h0000_0000);
    settle(8'h06);
    chk("rail", 32'(rail_enable), 32'h0000_0000);
    cmp <= 8'h07;
    repeat (3) @(posedge pclk);
    chk("rail", 32'(rail_enable), 32'h0000_0000);
    @(posedge pclk);
    chk("rail", 32'(rail_enable), 32'h0000_0001);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0000);
    chk("dev_n", 32'(device_reset_n), 32'h0000_0000);
    apb(1'b0, REG_STATUS, DATA_ZERO);
    chk("state", 32'(q[3:0]), 32'h0000_0002);
    settle(8'h05);
    chk("rail", 32'(rail_enable), 32'h0000_0001);
    settle(8'h01);
    chk("rail", 32'(rail_enable), 32'h0000_0000);
    settle(8'h05);
    chk("rail", 32'(rail_enable), 32'h0000_0000);
    settle(8'h0F);
    chk("rail", 32'(rail_enable), 32'h0000_0001);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0000);
    settle(8'h3F);
    chk("dev_n", 32'(device_reset_n), 32'h0000_0001);
    chk("hard_reset", 32'(hard_reset), 32'h0000_0000);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0000);
    settle(8'hFF);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0001);
    apb(1'b0, REG_STATUS, DATA_ZERO);
    chk("state", 32'(q[3:0]), 32'h0000_0008);
    // Software hold keeps the processor in reset while operating
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    @(posedge pclk);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0000);
    apb(1'b1, REG_CTRL, DATA_ZERO);
    @(posedge pclk);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0001);
    settle(8'hDF);
    chk("hard_reset", 32'(hard_reset), 32'h0000_0001);
    chk("proc_n", 32'(processor_reset_n), 32'h0000_0000);
    foreach (codes[k]) begin
      do_reset();
      settle(8'h3F);
      strap(codes[k]);
      idx = 0;
      for (int i = 0; i < IDX_N; i++) begin
        if (codes[k] > IDX_BOUND[i]) idx++;
      end
      chk("index", 32'(config_index), 32'(idx));
      chk("addr_a", 32'(target_addr_a),
          alt_idx[idx] ? 32'h0000_0023 : 32'h0000_0022);
      chk("addr_b", 32'(target_addr_b),
          alt_idx[idx] ? 32'h0000_0027 : 32'h0000_0026);
      chk("level", 32'(logic_level_low), 32'(low_idx[idx]));
      chk("boot", 32'(boot_mode), idx == 8 ? 32'h0000_0002 :
          32'(idx % 2));
      chk("cfg_valid", 32'(config_valid), 32'h0000_0001);
      strap(~codes[k]);
      chk("index", 32'(config_index), 32'(idx));
    end
    settle(8'h1F);
    chk("hard_reset", 32'(hard_reset), 32'h0000_0001);
    // Latch clears one edge after the hard reset rises
    @(posedge pclk);
    chk("cfg_valid", 32'(config_valid), 32'h0000_0000);
    complete_run();
  end
endmodule
